// *** design/nvcb_map.svh ***
// Purpose: constants for the non-volatile configuration bit block
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes: all counts are derived from times in their own units
//
// Overview of operation
// [RL1] Security bit set only by command
// [RL2] Security clears only after wipe and erase
// [RL3] Security off: all flash access allowed; the fast port still refuses NVCB_FP_BAD
// [RL4] Security on: debug and fast port refused
// [RL5] Programmer holds wipe pin over 50 ms
// [RL6] Wipe pin clears all region locks
// [RL7] Two persistent general-purpose bits held
// [RL8] Gp bits set only by commands
// [RL9] Gp bit 0 enables brownout detector
// [RL10] Wipe clears gp bit 0
// [RL11] Gp bit 1 gates brownout reset
// [RL12] Wipe clears gp bit 1
// [RL13] Eight factory calibration bits, read only
// [RL14] Wipe leaves calibration bits untouched
// [RL15] Test high, A B high, C low: fast mode
// [RL16] Fast port accepts seven command kinds
// [RL17] All straps high 10 s: boot recovery
// [RL18] Recovery rewrites first two sectors
// [RL19] Reset cause recorded from five sources
// [RL20] Brownout output follows detector while enabled
// [RL21] Bits exported as continuous levels
`ifndef NVCB_MAP_SVH
`define NVCB_MAP_SVH
`define NVCB_CLK_HZ 10000000
`define NVCB_WIPE_MS 50
`define NVCB_WIPE_CYC ((`NVCB_CLK_HZ / 1000) * `NVCB_WIPE_MS)
`define NVCB_RECOV_S 10
`define NVCB_RECOV_CYC (`NVCB_CLK_HZ * `NVCB_RECOV_S)
`define NVCB_CNT_W 27
`define NVCB_LOCK_N 16
`define NVCB_CAL_W 8
`define NVCB_CAL_RST 8'h00
`define NVCB_GP_BOD 0
`define NVCB_GP_BRST 1
`endif

// *** design/nvcb_pkg.sv ***
// Purpose: types for the non-volatile configuration bit block
// Assumes: nvcb_map.svh defines the widths
// Notes: types only
`include "nvcb_map.svh"
package nvcb_pkg;
    // Flash command interface commands
    typedef enum logic [2:0] {
        NVCB_CMD_NONE = 3'h0,
        NVCB_CMD_SET_SEC = 3'h1,
        NVCB_CMD_SET_GP = 3'h2,
        NVCB_CMD_CLR_GP = 3'h3,
        NVCB_CMD_SET_LOCK = 3'h4,
        NVCB_CMD_CLR_LOCK = 3'h5,
        NVCB_CMD_FULL_ERASE = 3'h6
    } nvcb_cmd_t;
    // Fast programming port commands
    typedef enum logic [2:0] {
        NVCB_FP_READ = 3'h0,
        NVCB_FP_PAGE_PROG = 3'h1,
        NVCB_FP_PAGE_ERASE = 3'h2,
        NVCB_FP_FULL_ERASE = 3'h3,
        NVCB_FP_LOCK = 3'h4,
        NVCB_FP_UNLOCK = 3'h5,
        NVCB_FP_PROTECT = 3'h6,
        NVCB_FP_BAD = 3'h7
    } nvcb_fp_cmd_t;
    // Reset causes
    typedef enum logic [2:0] {
        NVCB_RC_POWER = 3'h0,
        NVCB_RC_SOFT = 3'h1,
        NVCB_RC_USER = 3'h2,
        NVCB_RC_WDOG = 3'h3,
        NVCB_RC_BROWN = 3'h4
    } nvcb_rcause_t;
    // Command request from flash command controller
    typedef struct packed {
        logic valid;
        nvcb_cmd_t cmd;
        logic [3:0] arg;
    } nvcb_req_t;
    // Strap pins
    typedef struct packed {
        logic test_mode_pin;
        logic strap_line_a;
        logic strap_line_b;
        logic strap_line_c;
    } nvcb_strap_t;
    // Wipe filter states (Gray along idle, held, done)
    typedef enum logic [1:0] {
        NVCB_W_IDLE = 2'b00,
        NVCB_W_HELD = 2'b01,
        NVCB_W_DONE = 2'b11
    } nvcb_wst_t;
    typedef struct packed {
        nvcb_wst_t st;
        logic [`NVCB_CNT_W-1:0] cnt;
        logic done;
    } nvcb_wipe_state_t;
    typedef struct packed {
        logic [`NVCB_CNT_W-1:0] cnt;
        logic fast;
        logic recov;
    } nvcb_strap_state_t;
    typedef struct packed {
        logic sec;
        logic sec_wipe_pend;
        logic [1:0] gp;
        logic [`NVCB_LOCK_N-1:0] lock;
        logic [`NVCB_CAL_W-1:0] cal;
        logic cal_loaded;
        logic done;
        logic fp_ok;
        logic fp_refused;
        logic dbg_allow;
        logic bod_out;
        logic brst;
        nvcb_rcause_t rcause;
    } nvcb_top_state_t;
endpackage

// *** design/nvcb_wipe.sv ***
// Purpose: qualifies the wipe pin; pulses once it was held long enough
// Assumes: pin synchronous to clk
// Notes: shorter assertions are ignored entirely
`timescale 1ns/100ps
`default_nettype none
`include "nvcb_map.svh"
module nvcb_wipe #(
    parameter logic [`NVCB_CNT_W-1:0] HOLD_CYC = `NVCB_CNT_W'(`NVCB_WIPE_CYC)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_line_pin,
    // Pin and qualified event
    input wire logic wipe_pin,
    output logic wipe_done
);
    import nvcb_pkg::*;
    nvcb_wipe_state_t s_q, s_d;
    // Count the hold; fire one pulse per assertion
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            NVCB_W_IDLE: begin
                s_d.cnt = '0;
                if (wipe_pin) begin
                    s_d.st = NVCB_W_HELD;
                end
            end
            NVCB_W_HELD: begin
                if (!wipe_pin) begin
                    s_d.st = NVCB_W_IDLE;
                end else if (s_q.cnt == HOLD_CYC - 1'b1) begin
                    s_d.st = NVCB_W_DONE;
                    s_d.done = 1'b1; // see [RL5]
                end else begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            NVCB_W_DONE: begin
                if (!wipe_pin) begin
                    s_d.st = NVCB_W_IDLE;
                end
            end
            default: s_d.st = NVCB_W_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!reset_line_pin) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign wipe_done = s_q.done;
    wipe_short_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL5]
        !wipe_pin |=> !wipe_done) else $error("wipe pulse without pin");
endmodule
`default_nettype wire

// *** design/nvcb_strap.sv ***
// Purpose: decodes the mode straps and times the recovery hold
// Assumes: straps synchronous to clk
// Notes: recovery latches until reset, standing in for the power cycle
`timescale 1ns/100ps
`default_nettype none
`include "nvcb_map.svh"
module nvcb_strap #(
    parameter logic [`NVCB_CNT_W-1:0] RECOV_CYC = `NVCB_CNT_W'(`NVCB_RECOV_CYC)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_line_pin,
    // Straps
    input wire nvcb_pkg::nvcb_strap_t straps,
    // Decoded modes
    output logic fast_mode,
    output logic recovery
);
    import nvcb_pkg::*;
    nvcb_strap_state_t s_q, s_d;
    logic all_high;
    assign all_high = &straps;
    // Decode fast mode; time full-high straps
    always_comb begin
        s_d = s_q;
        s_d.fast = straps.test_mode_pin & straps.strap_line_a &
                   straps.strap_line_b & !straps.strap_line_c; // see [RL15]
        if (!all_high || s_q.recov) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == RECOV_CYC - 1'b1) begin
            s_d.recov = 1'b1; // see [RL17]
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_line_pin) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign fast_mode = s_q.fast & !s_q.recov;
    assign recovery = s_q.recov;
    recov_sticky_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL17]
        recovery |=> recovery) else $error("recovery dropped");
endmodule
`default_nettype wire

// *** design/nvcb_top.sv ***
// Purpose: non-volatile security, general-purpose, lock and calibration bits
// Assumes: one 10 MHz clock, synchronous active-low reset, pins synchronous
// Notes: flash array itself lives outside; this block holds bit state and gates
`timescale 1ns/100ps
`default_nettype none
`include "nvcb_map.svh"
module nvcb_top #(
    parameter logic [`NVCB_CNT_W-1:0] WIPE_CYC = `NVCB_CNT_W'(`NVCB_WIPE_CYC),
    parameter logic [`NVCB_CNT_W-1:0] RECOV_CYC = `NVCB_CNT_W'(`NVCB_RECOV_CYC),
    parameter logic [`NVCB_CAL_W-1:0] FACTORY_CAL = `NVCB_CAL_RST
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_line_pin,
    // Flash command controller requests
    input wire nvcb_pkg::nvcb_req_t req,
    output logic req_done,
    // Fast programming port
    input wire logic fp_valid,
    input wire nvcb_pkg::nvcb_fp_cmd_t fp_cmd,
    output logic fp_accept,
    output logic fp_refused,
    // In-circuit debug access gate
    output logic dbg_access_ok,
    // Pins
    input wire logic wipe_pin,
    input wire nvcb_pkg::nvcb_strap_t straps,
    // Mode outputs
    output logic fast_mode,
    output logic recovery_start,
    // Reset cause inputs, one-hot request levels
    input wire logic rst_soft,
    input wire logic rst_user,
    input wire logic rst_wdog,
    input wire logic brownout_sense,
    // Exported bits
    output logic security_bit,
    output logic [1:0] gp_bits,
    output logic bod_enable,
    output logic bod_out,
    output logic brownout_rst,
    output logic [`NVCB_CAL_W-1:0] cal_bits,
    output logic [`NVCB_LOCK_N-1:0] lock_bits,
    output nvcb_pkg::nvcb_rcause_t reset_cause
);
    import nvcb_pkg::*;
    nvcb_top_state_t s_q, s_d;
    logic wipe_done;
    logic fast_raw;
    logic recov_raw;
    logic fp_q;
    logic rec_q;

    // Wipe pin qualifier
    nvcb_wipe #(.HOLD_CYC(WIPE_CYC)) u_wipe (
        .clk(clk),
        .reset_line_pin(reset_line_pin),
        .wipe_pin(wipe_pin),
        .wipe_done(wipe_done)
    );
    // Strap decoder
    nvcb_strap #(.RECOV_CYC(RECOV_CYC)) u_strap (
        .clk(clk),
        .reset_line_pin(reset_line_pin),
        .straps(straps),
        .fast_mode(fast_raw),
        .recovery(recov_raw)
    );

    // Fast port command legality
    function automatic logic fp_legal(input nvcb_fp_cmd_t c);
        fp_legal = (c != NVCB_FP_BAD); // see [RL16]
    endfunction

    // Next state of all bits
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.fp_ok = 1'b0;
        s_d.fp_refused = 1'b0;
        // Calibration loads once from the factory value, then never written
        if (!s_q.cal_loaded) begin
            s_d.cal = FACTORY_CAL; // see [RL13]
            s_d.cal_loaded = 1'b1;
        end
        if (req.valid) begin
            s_d.done = 1'b1;
            unique case (req.cmd)
                NVCB_CMD_SET_SEC: s_d.sec = 1'b1; // see [RL1]
                NVCB_CMD_SET_GP: s_d.gp[req.arg[0]] = 1'b1; // see [RL8]
                NVCB_CMD_CLR_GP: s_d.gp[req.arg[0]] = 1'b0; // see [RL8]
                NVCB_CMD_SET_LOCK: s_d.lock[req.arg] = 1'b1;
                NVCB_CMD_CLR_LOCK: s_d.lock[req.arg] = 1'b0;
                NVCB_CMD_FULL_ERASE: begin
                    // Security drops only when wipe preceded this erase
                    if (s_q.sec_wipe_pend) begin
                        s_d.sec = 1'b0; // see [RL2]
                        s_d.sec_wipe_pend = 1'b0;
                    end
                end
                default: s_d.done = 1'b1;
            endcase
        end
        // Wipe wins over any gp or lock command in the same cycle
        if (wipe_done) begin
            s_d.lock = '0; // see [RL6]
            s_d.gp[`NVCB_GP_BOD] = 1'b0; // see [RL10]
            s_d.gp[`NVCB_GP_BRST] = 1'b0; // see [RL12]
            s_d.sec_wipe_pend = s_q.sec | s_d.sec;
        end
        // Fast port gated by security; unsecured grants every legal command, NVCB_FP_BAD still refused
        if (fp_valid && fast_raw) begin
            if (s_q.sec || !fp_legal(fp_cmd)) begin
                s_d.fp_refused = 1'b1; // see [RL4]
            end else begin
                s_d.fp_ok = 1'b1; // see [RL3]
            end
        end
        s_d.dbg_allow = !s_d.sec; // see [RL4]
        // Brownout path
        s_d.bod_out = s_d.gp[`NVCB_GP_BOD] & brownout_sense; // see [RL20]
        s_d.brst = s_d.bod_out & s_d.gp[`NVCB_GP_BRST]; // see [RL11]
        // Reset cause, priority brownout, watchdog, user, software
        if (s_d.brst) begin
            s_d.rcause = NVCB_RC_BROWN; // see [RL19]
        end else if (rst_wdog) begin
            s_d.rcause = NVCB_RC_WDOG;
        end else if (rst_user) begin
            s_d.rcause = NVCB_RC_USER;
        end else if (rst_soft) begin
            s_d.rcause = NVCB_RC_SOFT;
        end
    end

    // Bit storage; reset models power-up with bits at erased value
    always_ff @(posedge clk) begin
        if (!reset_line_pin) begin
            s_q <= '0;
            s_q.dbg_allow <= 1'b1;
            s_q.rcause <= NVCB_RC_POWER;
            fp_q <= 1'b0;
            rec_q <= 1'b0;
        end else begin
            s_q <= s_d;
            fp_q <= fast_raw;
            rec_q <= recov_raw; // see [RL18]
        end
    end

    // Registered exports; bits as continuous levels, done and fast-port answers as one-cycle pulses
    assign security_bit = s_q.sec; // see [RL21]
    assign gp_bits = s_q.gp; // see [RL7]
    assign bod_enable = s_q.gp[`NVCB_GP_BOD]; // see [RL9]
    assign bod_out = s_q.bod_out;
    assign brownout_rst = s_q.brst;
    assign cal_bits = s_q.cal; // see [RL14]
    assign lock_bits = s_q.lock;
    assign reset_cause = s_q.rcause;
    assign req_done = s_q.done;
    assign fp_accept = s_q.fp_ok;
    assign fp_refused = s_q.fp_refused;
    assign dbg_access_ok = s_q.dbg_allow;
    assign fast_mode = fp_q;
    assign recovery_start = rec_q;

    // Bit changes show one edge after the request edge, so look back one
    sec_no_clear_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL2]
        $fell(security_bit) |-> $past(s_q.sec_wipe_pend)) else $error("sec cleared");
    sec_set_cmd_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL1]
        $rose(security_bit) |-> $past(req.valid && req.cmd == NVCB_CMD_SET_SEC))
        else $error("sec set without command");
    fp_secure_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL4]
        fp_accept |-> !$past(security_bit)) else $error("fast access while secure");
    dbg_secure_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL4]
        security_bit |-> !dbg_access_ok) else $error("debug open while secure");
    wipe_clears_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL10]
        wipe_done |=> (gp_bits == 2'b00) && (lock_bits == '0)) else $error("wipe missed");
    cal_fixed_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL14]
        s_q.cal_loaded |=> $stable(cal_bits)) else $error("cal changed");
    bod_gate_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL9]
        bod_out |-> bod_enable) else $error("bod without enable");
    brst_gate_a: assert property (@(posedge clk) disable iff (!reset_line_pin) // see [RL11]
        brownout_rst |-> gp_bits[1] && reset_cause == NVCB_RC_BROWN)
        else $error("brownout reset gated wrong");
    wipe_cov_c: cover property (@(posedge clk) disable iff (!reset_line_pin) wipe_done);
    fp_cov_c: cover property (@(posedge clk) disable iff (!reset_line_pin) fp_accept);
    fpref_cov_c: cover property (@(posedge clk) disable iff (!reset_line_pin) fp_refused);
    unsec_cov_c: cover property (@(posedge clk) disable iff (!reset_line_pin) $fell(security_bit));
endmodule
`default_nettype wire

// *** testbench/nvcb_host_model.sv ***
// Purpose: stand-in for the flash command controller and the programmer
// Assumes: requests change on the falling clock edge
// Notes: released lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module nvcb_host_model (
    // Clock
    input wire logic clk,
    // Answers from the block
    input wire logic req_done,
    input wire logic fp_accept,
    input wire logic fp_refused,
    // Requests and pins
    output var nvcb_pkg::nvcb_req_t req,
    output var logic fp_valid,
    output var nvcb_pkg::nvcb_fp_cmd_t fp_cmd,
    output var logic wipe_pin,
    output var nvcb_pkg::nvcb_strap_t straps
);
    import nvcb_pkg::*;
    // Idle levels; the wipe pin rests at its pull-down level
    initial begin
        req = '0;
        fp_valid = 1'b0;
        fp_cmd = NVCB_FP_READ;
        wipe_pin = 1'b0;
        straps = '0;
    end
    // One-cycle command; done pulse stands only one cycle, so take it first
    task automatic cmd(input nvcb_cmd_t c, input logic [3:0] a, output logic done);
        @(negedge clk);
        req = '{valid: 1'b1, cmd: c, arg: a};
        @(negedge clk);
        done = req_done;
        req = '{valid: 1'b0, cmd: nvcb_cmd_t'(~c), arg: ~a};
    endtask
    // One fast-port request; returns {accept, refused} while they stand
    task automatic fp(input nvcb_fp_cmd_t c, output logic [1:0] ans);
        @(negedge clk);
        fp_valid = 1'b1;
        fp_cmd = c;
        @(negedge clk);
        ans = {fp_accept, fp_refused};
        fp_valid = 1'b0;
        fp_cmd = nvcb_fp_cmd_t'(~c);
    endtask
    // Wipe pin held for n cycles; long holds stand for the 50 ms minimum
    task automatic wipe(input int n);
        @(negedge clk);
        wipe_pin = 1'b1;
        repeat (n) @(negedge clk);
        wipe_pin = 1'b0;
    endtask
    // Strap pattern applied at a falling edge
    task automatic strap(input nvcb_strap_t s);
        @(negedge clk);
        straps = s;
    endtask
endmodule
`default_nettype wire

// *** testbench/nvcb_top_tb.sv ***
// Purpose: self-checking bench for the configuration bit block
// Assumes: short wipe and recovery counts set by parameter
// Notes: every wait is bounded and ends the run when exhausted
`timescale 1ns/100ps
`default_nettype none
module nvcb_top_tb;
    import nvcb_pkg::*;
    localparam logic [7:0] CAL = 8'h5a;
    logic clk, reset_line_pin, rst_soft, rst_user, rst_wdog, brownout_sense;
    logic req_done, fp_valid, fp_accept, fp_refused, dbg_access_ok, wipe_pin;
    logic fast_mode, recovery_start, security_bit, bod_enable, bod_out, brownout_rst;
    logic [1:0] gp_bits;
    logic [7:0] cal_bits;
    logic [15:0] lock_bits;
    nvcb_req_t req;
    nvcb_fp_cmd_t fp_cmd;
    nvcb_strap_t straps;
    nvcb_rcause_t reset_cause;
    int error_cnt, cmp_count;
    logic d;
    logic [1:0] ans;
    // Design with short counts
    nvcb_top #(.WIPE_CYC(27'h8), .RECOV_CYC(27'h10), .FACTORY_CAL(CAL)) dut (
        .clk, .reset_line_pin, .req, .req_done, .fp_valid, .fp_cmd, .fp_accept, .fp_refused,
        .dbg_access_ok, .wipe_pin, .straps, .fast_mode, .recovery_start, .rst_soft,
        .rst_user, .rst_wdog, .brownout_sense, .security_bit, .gp_bits, .bod_enable,
        .bod_out, .brownout_rst, .cal_bits, .lock_bits, .reset_cause);
    // Far side
    nvcb_host_model u_host (.clk, .req_done, .fp_accept, .fp_refused, .req, .fp_valid,
        .fp_cmd, .wipe_pin, .straps);
    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Exhausted wait counts as a mismatch and stops the run
    task automatic bound(input int i);
        if (i >= 40) begin
            error_cnt++;
            end_of_test();
        end
    endtask
    // Reset low for three rising edges, then three quiet cycles
    task automatic do_reset();
        reset_line_pin = 1'b0;
        repeat (3) @(negedge clk);
        reset_line_pin = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    task automatic t_reset();
        do_reset();
        chk(security_bit, 0);
        chk(dbg_access_ok, 1);
        chk({gp_bits, lock_bits}, 0);
        chk(reset_cause, NVCB_RC_POWER);
        chk(cal_bits, CAL);
        $display("test reset done");
    endtask
    task automatic t_gp();
        u_host.cmd(NVCB_CMD_SET_GP, 4'h0, d);
        chk({d, gp_bits, bod_enable}, 4'hb);
        u_host.cmd(NVCB_CMD_SET_GP, 4'h1, d);
        chk(gp_bits, 2'h3);
        u_host.cmd(NVCB_CMD_CLR_GP, 4'h0, d);
        chk({gp_bits, bod_enable}, 3'h4);
        u_host.cmd(NVCB_CMD_SET_LOCK, 4'h3, d);
        u_host.cmd(NVCB_CMD_SET_LOCK, 4'h5, d);
        chk({lock_bits, cal_bits}, {16'h0028, CAL});
        u_host.cmd(NVCB_CMD_CLR_LOCK, 4'h3, d);
        chk({d, lock_bits, cal_bits}, {1'b1, 16'h0020, CAL});
        $display("test gp done");
    endtask
    task automatic t_brown();
        brownout_sense = 1'b1;
        repeat (2) @(negedge clk);
        chk({bod_out, brownout_rst}, 0);
        u_host.cmd(NVCB_CMD_SET_GP, 4'h0, d);
        @(negedge clk);
        chk({bod_out, brownout_rst, reset_cause}, {2'h3, NVCB_RC_BROWN});
        u_host.cmd(NVCB_CMD_CLR_GP, 4'h1, d);
        repeat (2) @(negedge clk);
        chk({bod_out, brownout_rst}, 2'h2);
        brownout_sense = 1'b0;
        repeat (2) @(negedge clk);
        chk(bod_out, 0);
        // Each cause alone, one at a time
        rst_soft = 1'b1;
        repeat (3) @(negedge clk);
        chk(reset_cause, NVCB_RC_SOFT);
        rst_soft = 1'b0;
        rst_user = 1'b1;
        repeat (3) @(negedge clk);
        chk(reset_cause, NVCB_RC_USER);
        rst_user = 1'b0;
        rst_wdog = 1'b1;
        repeat (3) @(negedge clk);
        chk(reset_cause, NVCB_RC_WDOG);
        rst_wdog = 1'b0;
        $display("test brownout done");
    endtask
    task automatic go_fast();
        int i;
        u_host.strap('{1'b1, 1'b1, 1'b1, 1'b0});
        for (i = 0; i < 40 && fast_mode !== 1'b1; i++) @(negedge clk);
        bound(i);
    endtask
    task automatic t_fast();
        go_fast();
        chk(fast_mode, 1);
        for (int c = 0; c < 8; c++) begin
            u_host.fp(nvcb_fp_cmd_t'(c), ans);
            chk(ans, (c == 7) ? 2'h1 : 2'h2);
        end
        u_host.strap('{1'b1, 1'b1, 1'b0, 1'b0});
        repeat (3) @(negedge clk);
        chk(fast_mode, 0);
        $display("test fast done");
    endtask
    task automatic t_sec();
        go_fast();
        u_host.cmd(NVCB_CMD_SET_SEC, 4'h0, d);
        chk({security_bit, dbg_access_ok}, 2'h2);
        u_host.fp(NVCB_FP_READ, ans);
        chk(ans, 2'h1);
        u_host.cmd(NVCB_CMD_FULL_ERASE, 4'h0, d);
        chk(security_bit, 1);
        u_host.cmd(NVCB_CMD_SET_GP, 4'h1, d);
        u_host.wipe(4);
        repeat (4) @(negedge clk);
        chk(gp_bits, 2'h3);
        u_host.wipe(12);
        chk({gp_bits, lock_bits}, 0);
        chk({cal_bits, security_bit}, {CAL, 1'b1});
        u_host.cmd(NVCB_CMD_FULL_ERASE, 4'h0, d);
        chk({security_bit, dbg_access_ok}, 2'h1);
        u_host.fp(NVCB_FP_READ, ans);
        chk(ans, 2'h2);
        $display("test security done");
    endtask
    task automatic t_recov();
        int i;
        u_host.strap('{1'b1, 1'b1, 1'b1, 1'b1});
        for (i = 0; i < 40 && recovery_start !== 1'b1; i++) @(negedge clk);
        bound(i);
        chk(fast_mode, 0);
        u_host.strap('0);
        repeat (2) @(negedge clk);
        chk(recovery_start, 1);
        do_reset();
        chk(recovery_start, 0);
        $display("test recovery done");
    endtask
    // Main sequence
    initial begin
        {reset_line_pin, rst_soft, rst_user, rst_wdog, brownout_sense} = '0;
        error_cnt = 0;
        cmp_count = 0;
        t_reset();
        t_gp();
        t_brown();
        t_fast();
        t_sec();
        t_recov();
        end_of_test();
    end
endmodule
`default_nettype wire
